// [hdl/charger_status_defines.svh]
// Purpose: timing counts and codes for the charger status and fault control
// Assumes: 50 MHz system clock
// Notes: oscillator cycles are counted on the osc_tick_i strobe
`ifndef CHARGER_STATUS_DEFINES_SVH
`define CHARGER_STATUS_DEFINES_SVH
`define CLK_FREQ_HZ 50000000
`define STEP_TIME_MS 500
`define STEP_CYCLES ((`CLK_FREQ_HZ / 1000) * `STEP_TIME_MS)
`define FLASH_RATE_HZ 1
`define FLASH_HALF_CYCLES (`CLK_FREQ_HZ / (2 * `FLASH_RATE_HZ))
`define SHORT_CHECK_OSC 384
`define EOC_QUAL_OSC 3
`endif

// [hdl/charger_status_pkg.sv]
// Purpose: types for the charger status and fault control
// Assumes: nothing
// Notes: one-hot state codes
package charger_status_pkg;
   typedef enum logic [7:0] {
      ST_PLUG_RED = 8'b0000_0001,
      ST_PLUG_GRN = 8'b0000_0010,
      ST_PLUG_YEL = 8'b0000_0100,
      ST_IDLE = 8'b0000_1000,
      ST_SHORT_CHK = 8'b0001_0000,
      ST_CHARGE = 8'b0010_0000,
      ST_DONE = 8'b0100_0000,
      ST_LATCHED = 8'b1000_0000
   } charge_state_t;

   typedef struct packed {
      logic eoc_current_low;
      logic above_recharge;
      logic above_short_level;
      logic timeout_done;
      logic timeout_with_voltage;
      logic trickle_timeout;
   } core_status_t;

   typedef struct packed {
      logic above_cold_limit;
      logic below_cold_release;
      logic below_hot_limit;
      logic above_hot_release;
   } temp_compare_t;
endpackage : charger_status_pkg

// [hdl/charger_status_fault_control.sv]
// Purpose: indicator, recharge and ambient temperature control for a li-ion charger
// Assumes: inputs synchronous to clk_i; osc_tick_i one pulse per oscillator cycle
// Notes: indicator sinks active low, 1 means released
// How it works
// - after end-of-charge and charger off, recharge restarts below threshold, green stays
// - power-on steps red, green, yellow, off, each 500ms
// - charging drives red sink low, green released
// - qualified end-of-charge or timeout completion shows green
// - green holds until power cycle, enable removal or latched fault, recharge included
// - temperature fault shows steady yellow, self-clears when back in range
// - other faults flash yellow at 1Hz, latched until enable toggles
// - foldback low current gives no end-of-charge below recharge threshold
// - ambient out of window pauses charge, resumes once back in range
// - hot limit shift pin grounded unless charging
// - cold condition sets above 2.0V, clears below threshold less hysteresis
// - hot condition sets below 0.714V, clears above threshold plus hysteresis
// - short fault if below 1V after 384 oscillator cycles of trickle
// - end-of-charge needs voltage above recharge and low current for 3 oscillator cycles
`timescale 1ns/1ns
`include "charger_status_defines.svh"

module charger_status_fault_control #(
   parameter int STEP_CYCLES = `STEP_CYCLES,
   parameter int FLASH_HALF_CYCLES = `FLASH_HALF_CYCLES,
   parameter int SHORT_CHECK_OSC = `SHORT_CHECK_OSC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // battery enable and oscillator
   input wire logic enable_n_i,
   input wire logic osc_tick_i,
   // analog core status
   input wire charger_status_pkg::core_status_t core_i,
   input wire charger_status_pkg::temp_compare_t temp_i,
   // indicator and pins
   output logic red_indicator_sink_n_o,
   output logic green_indicator_sink_n_o,
   output logic hot_limit_shift_pin_o,
   output logic charge_on_o,
   output logic temp_fault_o
);
   import charger_status_pkg::*;

   charge_state_t state;
   charge_state_t next_state;
   logic [31:0] step_cnt;
   logic [31:0] flash_cnt;
   logic flash_phase;
   logic [15:0] osc_cnt;
   logic [2:0] eoc_cnt;
   logic green_latched;
   logic cold_flag;
   logic hot_flag;
   logic enable_n_q;
   logic seq_done;

   wire step_done = (step_cnt == 32'(STEP_CYCLES - 1));
   wire temp_bad = cold_flag | hot_flag;
   wire enable_rise = enable_n_i & ~enable_n_q;
   wire eoc_qual = (eoc_cnt >= 3'(`EOC_QUAL_OSC));
   // current low only counts with voltage above recharge, so foldback cannot end charge
   wire eoc_cond = core_i.eoc_current_low & core_i.above_recharge;
   wire finished = eoc_qual | (core_i.timeout_done & core_i.timeout_with_voltage);
   wire non_temp_fault = core_i.trickle_timeout |
      (core_i.timeout_done & ~core_i.timeout_with_voltage);
   wire short_done = (osc_cnt == 16'(SHORT_CHECK_OSC));
   wire charging = (state == ST_SHORT_CHK) | (state == ST_CHARGE);
   wire paused = charging & temp_bad;

   // hysteresis latches on the window comparators
   wire next_cold = cold_flag ? ~temp_i.below_cold_release : temp_i.above_cold_limit;
   wire next_hot = hot_flag ? ~temp_i.above_hot_release : temp_i.below_hot_limit;

   always_comb begin
      next_state = state;
      case (state)
         ST_PLUG_RED: if (step_done) next_state = ST_PLUG_GRN;
         ST_PLUG_GRN: if (step_done) next_state = ST_PLUG_YEL;
         ST_PLUG_YEL: if (step_done) next_state = ST_IDLE;
         ST_IDLE: begin
            if (!enable_n_i && !temp_bad && seq_done) next_state = ST_SHORT_CHK;
         end
         ST_SHORT_CHK: begin
            if (enable_n_i) next_state = ST_IDLE;
            else if (short_done && !core_i.above_short_level) next_state = ST_LATCHED;
            else if (short_done) next_state = ST_CHARGE;
         end
         ST_CHARGE: begin
            if (enable_n_i) next_state = ST_IDLE;
            else if (non_temp_fault) next_state = ST_LATCHED;
            else if (finished) next_state = ST_DONE;
         end
         ST_DONE: begin
            if (enable_n_i) next_state = ST_IDLE;
            else if (!core_i.above_recharge && !temp_bad) next_state = ST_SHORT_CHK;
         end
         ST_LATCHED: if (enable_rise) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_PLUG_RED;
         step_cnt <= 32'h0000_0000;
         flash_cnt <= 32'h0000_0000;
         flash_phase <= 1'b0;
         osc_cnt <= 16'h0000;
         eoc_cnt <= 3'h0;
         green_latched <= 1'b0;
         cold_flag <= 1'b0;
         hot_flag <= 1'b0;
         enable_n_q <= 1'b1;
         seq_done <= 1'b0;
      end else begin
         // ambient window freezes the sequencer and the short-check count and clears the eoc count
         if (!paused) state <= next_state;
         step_cnt <= (step_done || state != next_state) ? 32'h0000_0000 : step_cnt + 32'h1;
         if (flash_cnt == 32'(FLASH_HALF_CYCLES - 1)) begin
            flash_cnt <= 32'h0000_0000;
            flash_phase <= ~flash_phase;
         end else begin
            flash_cnt <= flash_cnt + 32'h1;
         end
         if (state != ST_SHORT_CHK) osc_cnt <= 16'h0000;
         else if (osc_tick_i && !short_done && !paused) osc_cnt <= osc_cnt + 16'h1;
         // low current while stopped is no end-of-charge
         if (state != ST_CHARGE || !eoc_cond || paused) eoc_cnt <= 3'h0;
         else if (osc_tick_i && !eoc_qual) eoc_cnt <= eoc_cnt + 3'h1;
         if (state == ST_DONE) green_latched <= 1'b1;
         else if (state == ST_IDLE || state == ST_LATCHED) green_latched <= 1'b0;
         cold_flag <= next_cold;
         hot_flag <= next_hot;
         enable_n_q <= enable_n_i;
         // off step of the plug-in sequence held once after power-on
         if (state == ST_IDLE && step_done) seq_done <= 1'b1;
      end
   end

   // indicator selection
   logic next_red_n;
   logic next_grn_n;
   always_comb begin
      next_red_n = 1'b1;
      next_grn_n = 1'b1;
      case (state)
         ST_PLUG_RED: next_red_n = 1'b0;
         ST_PLUG_GRN: next_grn_n = 1'b0;
         ST_PLUG_YEL: begin
            next_red_n = 1'b0;
            next_grn_n = 1'b0;
         end
         ST_SHORT_CHK, ST_CHARGE: begin
            if (green_latched) next_grn_n = 1'b0;
            else next_red_n = 1'b0;
         end
         ST_DONE: next_grn_n = 1'b0;
         ST_LATCHED: begin
            next_red_n = flash_phase;
            next_grn_n = flash_phase;
         end
         default: begin
            next_red_n = 1'b1;
            next_grn_n = 1'b1;
         end
      endcase
      if (temp_bad && state != ST_LATCHED && !state[0] && !state[1] && !state[2]) begin
         next_red_n = 1'b0;
         next_grn_n = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         red_indicator_sink_n_o <= 1'b1;
         green_indicator_sink_n_o <= 1'b1;
         hot_limit_shift_pin_o <= 1'b1;
         charge_on_o <= 1'b0;
         temp_fault_o <= 1'b0;
      end else begin
         red_indicator_sink_n_o <= next_red_n;
         green_indicator_sink_n_o <= next_grn_n;
         hot_limit_shift_pin_o <= ~charging;
         charge_on_o <= charging & ~temp_bad;
         temp_fault_o <= temp_bad;
      end
   end

   property p_shift_pin;
      @(posedge clk_i) disable iff (rst_i)
      charging |=> hot_limit_shift_pin_o == 1'b0;
   endproperty
   a_shift_pin: assert property (p_shift_pin) else $error("shift pin not released");

   property p_charge_red;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_CHARGE && !green_latched && !temp_bad) |=>
         (!red_indicator_sink_n_o && green_indicator_sink_n_o);
   endproperty
   a_charge_red: assert property (p_charge_red) else $error("charge not red");

   property p_done_green;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_DONE && !temp_bad) |=> (red_indicator_sink_n_o && !green_indicator_sink_n_o);
   endproperty
   a_done_green: assert property (p_done_green) else $error("done not green");

   property p_temp_yellow;
      @(posedge clk_i) disable iff (rst_i)
      (temp_bad && state == ST_IDLE) |=>
         (!red_indicator_sink_n_o && !green_indicator_sink_n_o);
   endproperty
   a_temp_yellow: assert property (p_temp_yellow) else $error("no yellow on temp");

   property p_flash_together;
      @(posedge clk_i) disable iff (rst_i)
      $past(state) == ST_LATCHED && state == ST_LATCHED |->
         red_indicator_sink_n_o == green_indicator_sink_n_o;
   endproperty
   a_flash_together: assert property (p_flash_together) else $error("flash split");

   property p_latched_hold;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_LATCHED && !enable_rise) |=> state == ST_LATCHED;
   endproperty
   a_latched_hold: assert property (p_latched_hold) else $error("fault left latch");

   property p_idle_dark;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_IDLE && !temp_bad) |=> (red_indicator_sink_n_o && green_indicator_sink_n_o);
   endproperty
   a_idle_dark: assert property (p_idle_dark) else $error("idle not dark");

   property p_cold_set;
      @(posedge clk_i) disable iff (rst_i)
      temp_i.above_cold_limit |=> cold_flag;
   endproperty
   a_cold_set: assert property (p_cold_set) else $error("cold not set");

   property p_hot_set;
      @(posedge clk_i) disable iff (rst_i)
      temp_i.below_hot_limit |=> hot_flag;
   endproperty
   a_hot_set: assert property (p_hot_set) else $error("hot not set");

   property p_pause;
      @(posedge clk_i) disable iff (rst_i)
      (charging && temp_bad) |=> $stable(state);
   endproperty
   a_pause: assert property (p_pause) else $error("charge not paused");

   property p_off_hold;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_IDLE && !seq_done) |=> state == ST_IDLE;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("off step cut short");

   property p_pause_eoc;
      @(posedge clk_i) disable iff (rst_i)
      paused |=> eoc_cnt == 3'h0;
   endproperty
   a_pause_eoc: assert property (p_pause_eoc) else $error("eoc counted while paused");

   property p_pause_off;
      @(posedge clk_i) disable iff (rst_i)
      paused |=> (!charge_on_o && temp_fault_o);
   endproperty
   a_pause_off: assert property (p_pause_off) else $error("paused charge still on");

   property p_foldback;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_CHARGE && !core_i.above_recharge) |=> eoc_cnt == 3'h0;
   endproperty
   a_foldback: assert property (p_foldback) else $error("eoc below recharge level");

   property p_eoc_done;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_CHARGE && eoc_qual && !non_temp_fault && !enable_n_i && !temp_bad) |=>
         state == ST_DONE;
   endproperty
   a_eoc_done: assert property (p_eoc_done) else $error("qualified eoc not done");

   property p_short_fault;
      @(posedge clk_i) disable iff (rst_i)
      (state == ST_SHORT_CHK && short_done && !core_i.above_short_level && !enable_n_i &&
         !temp_bad) |=> state == ST_LATCHED;
   endproperty
   a_short_fault: assert property (p_short_fault) else $error("short not latched");

   property p_recharge_green;
      @(posedge clk_i) disable iff (rst_i)
      (charging && green_latched && !temp_bad) |=>
         (red_indicator_sink_n_o && !green_indicator_sink_n_o);
   endproperty
   a_recharge_green: assert property (p_recharge_green) else $error("recharge not green");

   property p_cold_hold;
      @(posedge clk_i) disable iff (rst_i)
      (cold_flag && !temp_i.below_cold_release) |=> cold_flag;
   endproperty
   a_cold_hold: assert property (p_cold_hold) else $error("cold cleared early");

   property p_hot_hold;
      @(posedge clk_i) disable iff (rst_i)
      (hot_flag && !temp_i.above_hot_release) |=> hot_flag;
   endproperty
   a_hot_hold: assert property (p_hot_hold) else $error("hot cleared early");

   property p_shift_ground;
      @(posedge clk_i) disable iff (rst_i)
      !charging |=> hot_limit_shift_pin_o == 1'b1;
   endproperty
   a_shift_ground: assert property (p_shift_ground) else $error("shift pin not grounded");
endmodule : charger_status_fault_control

// [verif/cell_ntc_model.sv]
// Purpose: cell, thermistor divider and core flags seen by the charger control
// Assumes: millivolt levels set by the bench
// Notes: hysteresis widths are arbitrary defaults
`timescale 1ns/1ns
module cell_ntc_model
   import charger_status_pkg::*;
#(
   parameter int RECH_MV = 4000,
   parameter int HYS_COLD_MV = 200,
   parameter int HYS_HOT_MV = 150
) (
   // levels from the bench
   input wire logic [12:0] vbat_mv_i,
   input wire logic [11:0] temp_mv_i,
   input wire logic [3:0] flags_i,
   // comparator outputs
   output charger_status_pkg::core_status_t core_o,
   output charger_status_pkg::temp_compare_t temp_o
);
   wire logic above_rech = int'(vbat_mv_i) > RECH_MV;
   wire logic above_short = int'(vbat_mv_i) > 1000;
   assign core_o = {flags_i[3], above_rech, above_short, flags_i[2:0]};
   assign temp_o = {int'(temp_mv_i) > 2000, int'(temp_mv_i) < 2000 - HYS_COLD_MV,
                    int'(temp_mv_i) < 714, int'(temp_mv_i) > 714 + HYS_HOT_MV};
endmodule : cell_ntc_model

// [verif/charger_status_fault_control_test.sv]
// Purpose: self-checking bench for charger status and fault control
// Assumes: short step, flash and short-check counts
// Notes: oscillator ticks are random
`timescale 1ns/1ns
module charger_status_fault_control_test;
   import charger_status_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic enable_n_i = 1'b1;
   logic osc_tick_i = 1'b0;
   logic [12:0] vbat = 13'h0e74;
   logic [11:0] temp = 12'h05dc;
   logic [3:0] flags = 4'h0;
   core_status_t core;
   temp_compare_t tcmp;
   logic red, green_indicator_sink, shift, chg_on, tflt;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   int k;
   logic [31:0] rs = 32'h0000_4a0c;
   wire [1:0] led = {red, green_indicator_sink};
   always #10 clk_i = ~clk_i;
   cell_ntc_model cell_ntc_model_inst (.vbat_mv_i(vbat), .temp_mv_i(temp), .flags_i(flags),
      .core_o(core), .temp_o(tcmp));
   charger_status_fault_control #(.STEP_CYCLES(10), .FLASH_HALF_CYCLES(4),
      .SHORT_CHECK_OSC(4)) charger_status_fault_control_inst (.clk_i(clk_i), .rst_i(rst_i),
      .enable_n_i(enable_n_i), .osc_tick_i(osc_tick_i), .core_i(core), .temp_i(tcmp),
      .red_indicator_sink_n_o(red), .green_indicator_sink_n_o(green_indicator_sink),
      .hot_limit_shift_pin_o(shift), .charge_on_o(chg_on), .temp_fault_o(tflt));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction : xs
   // expected sinks: 0 red, 1 green, 2 yellow, 3 dark
   function automatic logic [1:0] lx(input int c);
      return c == 0 ? 2'b01 : c == 1 ? 2'b10 : c == 2 ? 2'b00 : 2'b11;
   endfunction : lx
   task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk_i);
         #2;
         rs = xs(rs);
         osc_tick_i = rs[0];
         cyc++;
         if (cyc > 3000) begin
            n_fail++;
            wrap_up();
         end
      end
   endtask : step
   task automatic flash_chk();
      int t;
      logic [1:0] p;
      t = 0;
      p = led;
      repeat (16) begin
         step(1);
         chk("flash_pair", {3'b000, led[1] ^ led[0]}, 4'h0);
         t += int'(led !== p);
         p = led;
      end
      chk("flash_rate", {3'b000, t inside {3, 4}}, 4'h1);
   endtask : flash_chk
   initial begin
      step(16);
      rst_i = 1'b0;
      for (k = 0; k < 4; k++) begin
         step(k == 0 ? 5 : 10);
         chk("plug_in", {2'b00, led}, {2'b00, lx(k)});
      end
      step(10);
      chk("idle", {led, shift, chg_on}, {lx(3), 2'b10});
      enable_n_i = 1'b0;
      for (k = 0; k < 80 && chg_on !== 1'b1; k++) step(1);
      step(30);
      chk("charging", {led, shift, chg_on}, {lx(0), 2'b01});
      flags = 4'h8;
      vbat = 13'h0bb8 + 13'(rs[8:0]);
      step(40);
      chk("foldback", {2'b00, led}, {2'b00, lx(0)});
      for (k = 0; k < 2; k++) begin
         temp = (k == 0) ? 12'h0834 : 12'h0258;
         step(3);
         chk("temp_set", {led, chg_on, tflt}, {lx(2), 2'b01});
         temp = (k == 0) ? 12'h076c : 12'h0320;
         // cell full and current low while stopped
         vbat = 13'h1004;
         step(8);
         chk("temp_hold", {led, chg_on, tflt}, {lx(2), 2'b01});
         temp = 12'h05dc;
         step(3);
         chk("temp_clear", {led, chg_on, tflt}, {lx(0), 2'b10});
         vbat = 13'h0bb8;
      end
      vbat = 13'h1004;
      for (k = 0; k < 80 && green_indicator_sink !== 1'b0; k++) step(1);
      step(2);
      chk("done", {2'b00, led}, {2'b00, lx(1)});
      flags = 4'h0;
      vbat = 13'h0e74;
      step(30);
      chk("recharge", {1'b0, led, chg_on}, {1'b0, lx(1), 1'b1});
      flags = 4'h1;
      step(4);
      flash_chk();
      flags = 4'h0;
      enable_n_i = 1'b1;
      step(3);
      chk("removed", {2'b00, led}, {2'b00, lx(3)});
      enable_n_i = 1'b0;
      step(30);
      flags = 4'h6;
      step(3);
      chk("timeout_ok", {2'b00, led}, {2'b00, lx(1)});
      flags = 4'h4;
      step(30);
      flash_chk();
      flags = 4'h0;
      enable_n_i = 1'b1;
      step(3);
      vbat = 13'h01f4;
      enable_n_i = 1'b0;
      step(40);
      flash_chk();
      rst_i = 1'b1;
      step(2);
      chk("reset", {led, shift, chg_on}, {lx(3), 2'b10});
      rst_i = 1'b0;
      for (k = 0; k < 5; k++) begin
         step(k == 0 ? 5 : 10);
         chk("replug", {led, shift, chg_on}, {lx(k % 4), k < 4 ? 2'b10 : 2'b01});
      end
      wrap_up();
   end
endmodule : charger_status_fault_control_test
